// ---- logic/pcc_cfg.svh ----
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PCC_NUM_QUEUES     4
`define PCC_QIDX_W         2
`define PCC_QUEUE_MAX      16'h0100
`define PCC_ADDR_W         12

// ----------------------------------------------------------------
// Capability constants
// ----------------------------------------------------------------
`define PCC_CAP_VENDOR     8'h09
`define PCC_TYPE_COMMON    8'h01
`define PCC_TYPE_NOTIFY    8'h02
`define PCC_TYPE_INT_STAT  8'h03
`define PCC_TYPE_DEVICE    8'h04
`define PCC_TYPE_CFG_ACC   8'h05
`define PCC_TYPE_SHMEM     8'h08
`define PCC_BAR_FIRST      8'h10
`define PCC_CAP0_PTR       8'h40
`define PCC_CAP1_PTR       8'h50
`define PCC_CAP0_LEN       8'h10
`define PCC_CAP1_LEN       8'h18
`define PCC_CAP_NEXT_END   8'h00
`define PCC_COMMON_BAR     8'h00
`define PCC_COMMON_OFS     32'h0000_0000
`define PCC_COMMON_LEN     32'h0000_0038
`define PCC_SHMEM_BAR      8'h02
`define PCC_SHMEM_TAG      8'h00
`define PCC_SHMEM_OFS_LO   32'h0000_0000
`define PCC_SHMEM_OFS_HI   32'h0000_0001
`define PCC_SHMEM_LEN_LO   32'h0000_0000
`define PCC_SHMEM_LEN_HI   32'h0000_0001
`define PCC_REVISION       8'h00

// ----------------------------------------------------------------
// Configuration header word offsets (bytes)
// ----------------------------------------------------------------
`define PCC_HDR_IDS        12'h000
`define PCC_HDR_REV        12'h008
`define PCC_HDR_SUBSYS     12'h02c
`define PCC_HDR_CAPPTR     12'h034

// ----------------------------------------------------------------
// Common configuration word offsets (bytes)
// ----------------------------------------------------------------
`define PCC_OFS_OFF_SEL    12'h000
`define PCC_OFS_OFF_BITS   12'h004
`define PCC_OFS_ACC_SEL    12'h008
`define PCC_OFS_ACC_BITS   12'h00c
`define PCC_OFS_VEC_NUMQ   12'h010
`define PCC_OFS_STAT_QSEL  12'h014
`define PCC_OFS_QSIZE_VEC  12'h018
`define PCC_OFS_QEN_NOTE   12'h01c
`define PCC_OFS_DESC_LO    12'h020
`define PCC_OFS_DESC_HI    12'h024
`define PCC_OFS_HRING_LO   12'h028
`define PCC_OFS_HRING_HI   12'h02c
`define PCC_OFS_URING_LO   12'h030
`define PCC_OFS_URING_HI   12'h034

`endif

// ---- logic/pcc_pkg.sv ----
package pcc_pkg;

  // ----------------------------------------------------------------
  // Access request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;   // Access strobe, one cycle
    logic        write;   // 1 write, 0 read
    logic [11:0] addr;    // Byte address, word aligned
    logic [3:0]  be;      // Byte lanes, lane 0 is lowest byte
    logic [31:0] wdata;   // Little-endian write word
  } pcc_acc_t;

  typedef struct packed {
    logic        valid;   // Read answer strobe, one cycle
    logic [31:0] rdata;   // Little-endian read word
  } pcc_rsp_t;

  // ----------------------------------------------------------------
  // Per-queue settings
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] depth;
    logic [15:0] vector;
    logic        active;
    logic [63:0] desc_addr;
    logic [63:0] host_ring;
    logic [63:0] used_ring;
  } pcc_queue_t;

endpackage : pcc_pkg

// ---- logic/pcc_common_cfg.sv ----
// Behaviour
// RL1: Transitional ids: revision zero, fixed ranges
// RL2: Multi-byte fields stored little-endian
// RL3: 64-bit fields as low then high words
// RL4: Host uses width-matched aligned accesses
// RL5: 64-bit halves accessed independently
// RL6: Capability starts vendor code, next link
// RL7: Structure type codes 1-5 and 8
// RL8: Capability length covers all its data
// RL9: BAR index 0..5 from offset 10h
// RL10: Host skips reserved type or index
// RL11: Host tolerates oversized lengths
// RL12: Host never writes capability fields; the testbench writes the word at 40h once to check that the write is ignored
// RL13: Wide capability appends offset, length highs
// RL14: Offered bits banked by selector
// RL15: Accepted bits banked by own selector
// RL16: Queue count read-only
// RL17: Writing zero status resets device
// RL18: Generation changes on configuration change
// RL19: Queue selector steers per-queue fields
// RL20: Queue depth resets to maximum; zero absent
// RL21: Enable reads 1/0; disabled queues idle
// RL22: Host writes three ring addresses
// RL23: Offered banks beyond defined read zero
// RL24: Status reads zero after reset
// RL25: Every queue enable zero on reset
// RL26: Independent per-queue copies; RO writes ignored
`timescale 1ns/1ns
`include "pcc_cfg.svh"

module pcc_common_cfg #(
  parameter logic [15:0] VENDOR_CODE  = 16'h5a5a,  // Arbitrary value
  parameter logic [15:0] DEVICE_CODE  = 16'h1010,  // Arbitrary, inside transitional range
  parameter logic [15:0] SUBSYS_VEND  = 16'h5a5a,  // Arbitrary value
  parameter logic [15:0] DEVICE_TYPE  = 16'h0010   // Arbitrary device-type number
) (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst,
  input  wire logic                                       ce,
  input  wire pcc_pkg::pcc_acc_t                          cfg_req,
  input  wire pcc_pkg::pcc_acc_t                          bar_req,
  input  wire logic [63:0]                                offered_features,
  input  wire logic                                       devcfg_changed,
  input  wire logic                                       devcfg_read,
  output pcc_pkg::pcc_rsp_t                               cfg_rsp,
  output pcc_pkg::pcc_rsp_t                               bar_rsp,
  output logic [63:0]                                     accepted_features,
  output logic [7:0]                                      status_byte,
  output logic [7:0]                                      generation,
  output logic                                            dev_reset,
  output pcc_pkg::pcc_queue_t [`PCC_NUM_QUEUES-1:0]       queue_cfg,
  output logic [`PCC_NUM_QUEUES-1:0]                      queue_enabled
);

  localparam int NQ = `PCC_NUM_QUEUES;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Merge written byte lanes into an old word, lane 0 is lowest byte
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];  // see RL2
      end
    end
    return r;
  endfunction : lane_merge

  // Pick the 32-bit group of a 64-bit feature set, zero past group 1
  function automatic logic [31:0] bank_pick(input logic [63:0] bits,
                                            input logic [31:0] sel);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (sel == 32'h0000_0000) begin
      r = bits[31:0];  // see RL14
    end else if (sel == 32'h0000_0001) begin
      r = bits[63:32];  // see RL14
    end
    return r;  // see RL23
  endfunction : bank_pick

  // ----------------------------------------------------------------
  // Common configuration state
  // ----------------------------------------------------------------
  logic [31:0]            off_sel_ff;       // Offered bank selector
  logic [31:0]            nxt_off_sel;
  logic [31:0]            acc_sel_ff;       // Accepted bank selector
  logic [31:0]            nxt_acc_sel;
  logic [63:0]            acc_bits_ff;      // Accepted feature bits
  logic [63:0]            nxt_acc_bits;
  logic [15:0]            cfg_vec_ff;       // Configuration change vector
  logic [15:0]            nxt_cfg_vec;
  logic [7:0]             status_ff;        // Host status byte
  logic [7:0]             nxt_status;
  logic [7:0]             gen_ff;           // Configuration change counter
  logic [7:0]             nxt_gen;
  logic                   chg_pend_ff;      // Change seen, not yet counted
  logic                   nxt_chg_pend;
  logic [15:0]            qsel_ff;          // Queue index selector
  logic [15:0]            nxt_qsel;
  logic                   dev_rst_ff;       // Soft reset pulse
  logic                   nxt_dev_rst;
  pcc_pkg::pcc_queue_t    q_ff  [NQ];       // Per-queue copies
  pcc_pkg::pcc_queue_t    nxt_q [NQ];

  // Selected queue decode
  logic                   q_ok;             // Selector names an existing queue
  logic [`PCC_QIDX_W-1:0] q_idx;            // Index into the copies
  logic [31:0]            cur_w;            // Current value of addressed word
  logic [31:0]            mrg_w;            // Word after byte-lane merge
  logic                   bar_wr;           // Write strobe on the BAR port

  assign q_ok   = (qsel_ff < 16'(NQ));  // see RL19
  assign q_idx  = qsel_ff[`PCC_QIDX_W-1:0];
  assign bar_wr = bar_req.valid && bar_req.write;

  // Current content of the word the BAR port addresses
  always_comb begin
    cur_w = 32'h0000_0000;
    unique case (bar_req.addr)
      `PCC_OFS_OFF_SEL:   cur_w = off_sel_ff;
      `PCC_OFS_OFF_BITS:  cur_w = bank_pick(offered_features, off_sel_ff);  // see RL14
      `PCC_OFS_ACC_SEL:   cur_w = acc_sel_ff;
      `PCC_OFS_ACC_BITS:  cur_w = bank_pick(acc_bits_ff, acc_sel_ff);       // see RL15
      `PCC_OFS_VEC_NUMQ:  cur_w = {16'(NQ), cfg_vec_ff};                    // see RL16
      `PCC_OFS_STAT_QSEL: cur_w = {qsel_ff, gen_ff, status_ff};
      `PCC_OFS_QSIZE_VEC: begin
        if (q_ok) begin
          cur_w = {q_ff[q_idx].vector, q_ff[q_idx].depth};  // see RL20
        end
      end
      `PCC_OFS_QEN_NOTE: begin
        if (q_ok) begin
          // Doorbell index equals queue number
          cur_w = {qsel_ff, 15'h0000, q_ff[q_idx].active};  // see RL21
        end
      end
      `PCC_OFS_DESC_LO:   if (q_ok) cur_w = q_ff[q_idx].desc_addr[31:0];   // see RL3
      `PCC_OFS_DESC_HI:   if (q_ok) cur_w = q_ff[q_idx].desc_addr[63:32];
      `PCC_OFS_HRING_LO:  if (q_ok) cur_w = q_ff[q_idx].host_ring[31:0];
      `PCC_OFS_HRING_HI:  if (q_ok) cur_w = q_ff[q_idx].host_ring[63:32];
      `PCC_OFS_URING_LO:  if (q_ok) cur_w = q_ff[q_idx].used_ring[31:0];
      `PCC_OFS_URING_HI:  if (q_ok) cur_w = q_ff[q_idx].used_ring[63:32];
      default:            cur_w = 32'h0000_0000;
    endcase
  end

  assign mrg_w = lane_merge(cur_w, bar_req.wdata, bar_req.be);

  // ----------------------------------------------------------------
  // Next state of the common configuration
  // ----------------------------------------------------------------
  always_comb begin
    nxt_off_sel  = off_sel_ff;
    nxt_acc_sel  = acc_sel_ff;
    nxt_acc_bits = acc_bits_ff;
    nxt_cfg_vec  = cfg_vec_ff;
    nxt_status   = status_ff;
    nxt_qsel     = qsel_ff;
    nxt_dev_rst  = 1'b0;
    nxt_q        = q_ff;
    // Count a change only when the host reads after it; a new change wins
    nxt_gen      = gen_ff;
    nxt_chg_pend = chg_pend_ff || devcfg_changed;
    if (devcfg_read && chg_pend_ff) begin
      nxt_gen      = gen_ff + 8'h01;     // see RL18
      nxt_chg_pend = devcfg_changed;     // see RL18
    end
    // Host writes, each word decoded once
    if (bar_wr) begin
      unique case (bar_req.addr)
        `PCC_OFS_OFF_SEL:  nxt_off_sel = mrg_w;
        `PCC_OFS_ACC_SEL:  nxt_acc_sel = mrg_w;
        `PCC_OFS_ACC_BITS: begin
          // Only bits on offer are kept
          if (acc_sel_ff == 32'h0000_0000) begin
            nxt_acc_bits[31:0] = mrg_w & offered_features[31:0];    // see RL15
          end else if (acc_sel_ff == 32'h0000_0001) begin
            nxt_acc_bits[63:32] = mrg_w & offered_features[63:32];  // see RL15
          end
        end
        `PCC_OFS_VEC_NUMQ:  nxt_cfg_vec = mrg_w[15:0];   // see RL26
        `PCC_OFS_STAT_QSEL: begin
          nxt_qsel = mrg_w[31:16];                       // see RL19
          if (bar_req.be[0]) begin
            nxt_status = mrg_w[7:0];
            if (mrg_w[7:0] == 8'h00) begin
              nxt_dev_rst = 1'b1;                        // see RL17
            end
          end
        end
        `PCC_OFS_QSIZE_VEC: begin
          if (q_ok) begin
            nxt_q[q_idx].depth  = mrg_w[15:0];           // see RL20
            nxt_q[q_idx].vector = mrg_w[31:16];
          end
        end
        `PCC_OFS_QEN_NOTE: begin
          // Doorbell half is read-only
          if (q_ok && bar_req.be[0]) begin
            nxt_q[q_idx].active = mrg_w[0];              // see RL26
          end
        end
        `PCC_OFS_DESC_LO:  if (q_ok) nxt_q[q_idx].desc_addr[31:0]  = mrg_w;  // see RL5
        `PCC_OFS_DESC_HI:  if (q_ok) nxt_q[q_idx].desc_addr[63:32] = mrg_w;  // see RL5
        `PCC_OFS_HRING_LO: if (q_ok) nxt_q[q_idx].host_ring[31:0]  = mrg_w;  // see RL22
        `PCC_OFS_HRING_HI: if (q_ok) nxt_q[q_idx].host_ring[63:32] = mrg_w;
        `PCC_OFS_URING_LO: if (q_ok) nxt_q[q_idx].used_ring[31:0]  = mrg_w;
        `PCC_OFS_URING_HI: if (q_ok) nxt_q[q_idx].used_ring[63:32] = mrg_w;
        default: begin
          // Read-only or unmapped words ignore writes
          nxt_status = status_ff;                        // see RL26
        end
      endcase
    end
    // Zero status returns everything but the generation count and its pending change to reset values
    if (nxt_dev_rst) begin
      nxt_off_sel  = 32'h0000_0000;
      nxt_acc_sel  = 32'h0000_0000;
      nxt_acc_bits = 64'h0;
      nxt_cfg_vec  = 16'h0000;
      nxt_status   = 8'h00;                              // see RL24
      nxt_qsel     = 16'h0000;
      for (int i = 0; i < NQ; i++) begin
        nxt_q[i]        = '0;
        nxt_q[i].depth  = `PCC_QUEUE_MAX;                // see RL20
        nxt_q[i].active = 1'b0;                          // see RL25
      end
    end
  end

  // ----------------------------------------------------------------
  // Register the common configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      off_sel_ff  <= 32'h0000_0000;
      acc_sel_ff  <= 32'h0000_0000;
      acc_bits_ff <= 64'h0;
      cfg_vec_ff  <= 16'h0000;
      status_ff   <= 8'h00;
      gen_ff      <= 8'h00;
      chg_pend_ff <= 1'b0;
      qsel_ff     <= 16'h0000;
      dev_rst_ff  <= 1'b0;
      for (int i = 0; i < NQ; i++) begin
        q_ff[i]        <= '0;
        q_ff[i].depth  <= `PCC_QUEUE_MAX;                // see RL20
        q_ff[i].active <= 1'b0;                          // see RL25
      end
    end else if (ce) begin
      off_sel_ff  <= nxt_off_sel;
      acc_sel_ff  <= nxt_acc_sel;
      acc_bits_ff <= nxt_acc_bits;
      cfg_vec_ff  <= nxt_cfg_vec;
      status_ff   <= nxt_status;
      gen_ff      <= nxt_gen;
      chg_pend_ff <= nxt_chg_pend;
      qsel_ff     <= nxt_qsel;
      dev_rst_ff  <= nxt_dev_rst;
      q_ff        <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration space capability words
  // ----------------------------------------------------------------
  logic [31:0] cfg_w;   // Word addressed on the configuration port

  // Read-only header and capability chain; writes are ignored
  always_comb begin
    cfg_w = 32'h0000_0000;
    unique case (cfg_req.addr)
      `PCC_HDR_IDS:    cfg_w = {DEVICE_CODE, VENDOR_CODE};          // see RL1
      `PCC_HDR_REV:    cfg_w = {24'h000000, `PCC_REVISION};         // see RL1
      `PCC_HDR_SUBSYS: cfg_w = {DEVICE_TYPE, SUBSYS_VEND};          // see RL1
      `PCC_HDR_CAPPTR: cfg_w = {24'h000000, `PCC_CAP0_PTR};
      // Common configuration locator
      {4'h0, `PCC_CAP0_PTR}: cfg_w = {`PCC_TYPE_COMMON, `PCC_CAP0_LEN,
                                      `PCC_CAP1_PTR, `PCC_CAP_VENDOR};  // see RL6
      {4'h0, `PCC_CAP0_PTR} + 12'h004: cfg_w = {16'h0000, 8'h00, `PCC_COMMON_BAR};  // see RL9
      {4'h0, `PCC_CAP0_PTR} + 12'h008: cfg_w = `PCC_COMMON_OFS;
      {4'h0, `PCC_CAP0_PTR} + 12'h00c: cfg_w = `PCC_COMMON_LEN;     // see RL8
      // Wide locator for a shared memory region
      {4'h0, `PCC_CAP1_PTR}: cfg_w = {`PCC_TYPE_SHMEM, `PCC_CAP1_LEN,
                                      `PCC_CAP_NEXT_END, `PCC_CAP_VENDOR};  // see RL7
      {4'h0, `PCC_CAP1_PTR} + 12'h004: cfg_w = {16'h0000, `PCC_SHMEM_TAG, `PCC_SHMEM_BAR};
      {4'h0, `PCC_CAP1_PTR} + 12'h008: cfg_w = `PCC_SHMEM_OFS_LO;
      {4'h0, `PCC_CAP1_PTR} + 12'h00c: cfg_w = `PCC_SHMEM_LEN_LO;
      {4'h0, `PCC_CAP1_PTR} + 12'h010: cfg_w = `PCC_SHMEM_OFS_HI;   // see RL13
      {4'h0, `PCC_CAP1_PTR} + 12'h014: cfg_w = `PCC_SHMEM_LEN_HI;   // see RL13
      default:         cfg_w = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  pcc_pkg::pcc_rsp_t cfg_rsp_ff;    // Configuration port answer
  pcc_pkg::pcc_rsp_t nxt_cfg_rsp;
  pcc_pkg::pcc_rsp_t bar_rsp_ff;    // BAR port answer
  pcc_pkg::pcc_rsp_t nxt_bar_rsp;

  // Answer one cycle after each read strobe
  always_comb begin
    nxt_cfg_rsp.valid = cfg_req.valid && !cfg_req.write;
    nxt_cfg_rsp.rdata = nxt_cfg_rsp.valid ? cfg_w : 32'h0000_0000;
    nxt_bar_rsp.valid = bar_req.valid && !bar_req.write;
    nxt_bar_rsp.rdata = nxt_bar_rsp.valid ? cur_w : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_rsp_ff <= '0;
      bar_rsp_ff <= '0;
    end else if (ce) begin
      cfg_rsp_ff <= nxt_cfg_rsp;
      bar_rsp_ff <= nxt_bar_rsp;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rsp           = cfg_rsp_ff;
  assign bar_rsp           = bar_rsp_ff;
  assign accepted_features = acc_bits_ff;
  assign status_byte       = status_ff;
  assign generation        = gen_ff;
  assign dev_reset         = dev_rst_ff;

  // Device logic may only serve queues whose enable is set
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      queue_cfg[i]     = q_ff[i];
      queue_enabled[i] = q_ff[i].active;  // see RL21
    end
  end

endmodule : pcc_common_cfg

// ---- tb/pcc_cfg_asserts.sv ----
`timescale 1ns/1ns
`include "pcc_cfg.svh"

module pcc_cfg_asserts (
  input wire logic                                 sys_clk,
  input wire logic                                 rst,
  input wire logic                                 ce,
  input wire pcc_pkg::pcc_acc_t                    cfg_req,
  input wire pcc_pkg::pcc_acc_t                    bar_req,
  input wire logic [63:0]                          offered_features,
  input wire logic                                 devcfg_read,
  input wire pcc_pkg::pcc_rsp_t                    cfg_rsp,
  input wire pcc_pkg::pcc_rsp_t                    bar_rsp,
  input wire logic [63:0]                          accepted_features,
  input wire logic [7:0]                           status_byte,
  input wire logic [7:0]                           generation,
  input wire logic                                 dev_reset,
  input wire pcc_pkg::pcc_queue_t [`PCC_NUM_QUEUES-1:0] queue_cfg,
  input wire logic [`PCC_NUM_QUEUES-1:0]           queue_enabled
);
  // ----------------------------------------------------------------
  // Register access timing and state rules
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_BAR_READ_ANSWER: assert property (ce && bar_req.valid && !bar_req.write |=> bar_rsp.valid)
    else $error("bar read not answered");
  AST_CFG_READ_ANSWER: assert property (ce && cfg_req.valid && !cfg_req.write |=> cfg_rsp.valid)
    else $error("cfg read not answered");
  AST_BAR_ANSWER_CAUSE: assert property (bar_rsp.valid |-> $past(bar_req.valid) && !$past(bar_req.write))
    else $error("bar answer without read");
  AST_ZERO_STATUS_RESET: assert property (ce && bar_req.valid && bar_req.write
    && bar_req.addr == `PCC_OFS_STAT_QSEL && bar_req.be[0] && bar_req.wdata[7:0] == 8'h00
    |=> dev_reset && status_byte == 8'h00) else $error("zero status did not reset");
  AST_RESET_CLEARS: assert property (dev_reset |-> queue_enabled == 4'h0 && status_byte == 8'h00
    && queue_cfg[0].depth == `PCC_QUEUE_MAX) else $error("soft reset left state");
  AST_RESET_PULSE: assert property (dev_reset |=> !dev_reset)
    else $error("reset pulse too long");
  AST_GEN_CAUSE: assert property (!$stable(generation) |-> $past(devcfg_read))
    else $error("generation moved without read");
  AST_GEN_STEP: assert property (!$stable(generation) |-> generation == $past(generation) + 8'h01)
    else $error("generation step wrong");
  AST_ACCEPT_MASK: assert property ((accepted_features & ~offered_features) == 64'h0)
    else $error("accepted bit not offered");
  AST_ENABLE_MATCH: assert property (queue_enabled == {queue_cfg[3].active, queue_cfg[2].active,
    queue_cfg[1].active, queue_cfg[0].active}) else $error("enable flags disagree");

endmodule : pcc_cfg_asserts

bind pcc_common_cfg pcc_cfg_asserts chk_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .cfg_req(cfg_req), .bar_req(bar_req), .offered_features(offered_features),
  .devcfg_read(devcfg_read), .cfg_rsp(cfg_rsp), .bar_rsp(bar_rsp),
  .accepted_features(accepted_features), .status_byte(status_byte), .generation(generation),
  .dev_reset(dev_reset), .queue_cfg(queue_cfg), .queue_enabled(queue_enabled));

// ---- tb/pcc_host_model.sv ----
`timescale 1ns/1ns

module pcc_host_model (
  input wire logic               sys_clk,
  output pcc_pkg::pcc_acc_t      cfg_req,
  output pcc_pkg::pcc_acc_t      bar_req,
  input wire pcc_pkg::pcc_rsp_t  cfg_rsp,
  input wire pcc_pkg::pcc_rsp_t  bar_rsp
);
  // ----------------------------------------------------------------
  // Idle buses at start
  // ----------------------------------------------------------------
  initial begin
    cfg_req = '0;
    bar_req = '0;
  end

  // ----------------------------------------------------------------
  // One access; byte lanes as the caller gives them, reads through rdc use all four
  // ----------------------------------------------------------------
  task automatic xfer(input logic b, input logic w, input logic [11:0] a,
                      input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
    pcc_pkg::pcc_acc_t r;
    int                n;
    r = '{valid: 1'b1, write: w, addr: a, be: be, wdata: d};
    @(posedge sys_clk);
    if (b) bar_req <= r; else cfg_req <= r;
    @(posedge sys_clk);
    // Released lines show inverted values, not the last ones
    r = '{valid: 1'b0, write: ~w, addr: ~a, be: ~be, wdata: ~d};
    if (b) bar_req <= r; else cfg_req <= r;
    q = 32'h0;
    if (!w) begin
      #1;
      for (n = 0; n < 4 && (b ? bar_rsp.valid : cfg_rsp.valid) !== 1'b1; n++) begin
        @(posedge sys_clk);
        #1;
      end
      q = b ? bar_rsp.rdata : cfg_rsp.rdata;
    end
  endtask : xfer

endmodule : pcc_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`include "pcc_cfg.svh"

module testbench;
  localparam logic [15:0] VEND  = 16'h6b6b;  // Arbitrary value
  localparam logic [15:0] DEVC  = 16'h1022;  // Arbitrary, transitional range
  localparam logic [15:0] DTYP  = 16'h0022;  // Arbitrary type number
  localparam logic [63:0] OFFER = 64'hc3a5_0f0f_9696_5aa5;
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, chg = 1'b0, rdd = 1'b0;
  pcc_pkg::pcc_acc_t cfg_req, bar_req;
  pcc_pkg::pcc_rsp_t cfg_rsp, bar_rsp;
  logic [63:0] acc;
  logic [7:0]  stat, gen;
  logic        dres;
  pcc_pkg::pcc_queue_t [`PCC_NUM_QUEUES-1:0] qcfg;
  logic [3:0]  qen;
  logic [31:0] cap [10] = '{32'h0110_5009, 32'h0, 32'h0, 32'h38, 32'h0818_0009,
                            32'h2, 32'h0, 32'h0, 32'h1, 32'h1};
  int failures = 0, checks_done = 0, i, j;

  always #5 sys_clk = ~sys_clk;  // 100 MHz

  // ----------------------------------------------------------------
  // Device, host model
  // ----------------------------------------------------------------
  pcc_common_cfg #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEVC), .SUBSYS_VEND(VEND),
    .DEVICE_TYPE(DTYP)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cfg_req(cfg_req),
    .bar_req(bar_req), .offered_features(OFFER), .devcfg_changed(chg), .devcfg_read(rdd),
    .cfg_rsp(cfg_rsp), .bar_rsp(bar_rsp), .accepted_features(acc), .status_byte(stat),
    .generation(gen), .dev_reset(dres), .queue_cfg(qcfg), .queue_enabled(qen));
  pcc_host_model host (.sys_clk(sys_clk), .cfg_req(cfg_req), .bar_req(bar_req),
    .cfg_rsp(cfg_rsp), .bar_rsp(bar_rsp));

  // ----------------------------------------------------------------
  // Compare, access helpers, closing
  // ----------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic b, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(b, 1'b1, a, be, d, q);
  endtask : wr

  task rdc(input logic b, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(b, 1'b0, a, 4'hf, 32'h0, q);
    chk(64'(q), 64'(e));
  endtask : rdc

  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Watchdog
  initial begin
    #100000;
    failures++;
    conclude;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(1'b1, 12'h014, 32'h0);
    rdc(1'b1, 12'h018, 32'h0000_0100);
    rdc(1'b0, 12'h000, {DEVC, VEND});
    host.xfer(1'b0, 1'b0, 12'h008, 4'hf, 32'h0, q);
    chk(64'(q[7:0]), 64'h0);
    rdc(1'b0, 12'h02c, {DTYP, VEND});
    wr(1'b0, 12'h040, 4'hf, 32'hffff_ffff);
    // Chain codes are all defined, so a host keeps both
    for (i = 0; i < 10; i++) rdc(1'b0, 12'h040 + 12'(4 * i), cap[i]);
    for (i = 0; i < 3; i++) begin
      wr(1'b1, 12'h000, 4'hf, 32'(i));
      rdc(1'b1, 12'h004, i == 2 ? 32'h0 : OFFER[32*i+:32]);
    end
    wr(1'b1, 12'h000, 4'hf, 32'h0);
    wr(1'b1, 12'h004, 4'hf, 32'h0);
    rdc(1'b1, 12'h004, OFFER[31:0]);
    for (i = 1; i >= 0; i--) begin
      wr(1'b1, 12'h008, 4'hf, 32'(i));
      wr(1'b1, 12'h00c, 4'hf, 32'hffff_ffff);
      rdc(1'b1, 12'h00c, OFFER[32*i+:32]);
    end
    chk(acc, OFFER);
    wr(1'b1, 12'h010, 4'hf, 32'hffff_ffff);
    rdc(1'b1, 12'h010, 32'h0004_ffff);
    for (i = 0; i < 4; i++) begin
      wr(1'b1, 12'h014, 4'hc, {16'(i), 16'h0});
      wr(1'b1, 12'h018, 4'hf, {16'h0a00 + 16'(i), 16'h0010 << i});
      // Host fills the three ring addresses of the selected queue
      for (j = 5; j >= 0; j--) wr(1'b1, 12'h020 + 12'(4 * j), 4'hf, {8'(j), 8'h5c, 16'(i)});
      wr(1'b1, 12'h01c, 4'h1, 32'(i % 2));
    end
    for (i = 0; i < 4; i++) begin
      wr(1'b1, 12'h014, 4'hc, {16'(i), 16'h0});
      rdc(1'b1, 12'h018, {16'h0a00 + 16'(i), 16'h0010 << i});
      rdc(1'b1, 12'h01c, {16'(i), 16'(i % 2)});
      for (j = 0; j < 6; j++) rdc(1'b1, 12'h020 + 12'(4 * j), {8'(j), 8'h5c, 16'(i)});
    end
    chk(qen, 4'b1010);
    chk(qcfg[2].desc_addr, 64'h015c_0002_005c_0002);
    wr(1'b1, 12'h014, 4'hc, 32'h0004_0000);
    rdc(1'b1, 12'h018, 32'h0);
    wr(1'b1, 12'h014, 4'h1, 32'h0000_000f);
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      chg <= (i == 0);
      @(posedge sys_clk);
      chg <= 1'b0;
      rdd <= 1'b1;
      @(posedge sys_clk);
      rdd <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(64'(gen), 64'h1);
    end
    rdc(1'b1, 12'h014, 32'h0004_010f);
    chk(64'(stat), 64'h0f);
    wr(1'b1, 12'h014, 4'h1, 32'h0);
    rdc(1'b1, 12'h014, 32'h0000_0100);
    chk(64'(qen), 64'h0);
    rdc(1'b1, 12'h018, 32'h0000_0100);
    chk(acc, 64'h0);
    conclude;
  end

endmodule : testbench
